// File: pkg/rcd_params.svh
// Purpose: Named constants for the receive clock distribution block.
// Assumes: Frequencies are kept in kHz, 24 bits wide.
// Notes:   Register offsets are byte addresses on a 32-bit Wishbone bus.
`ifndef RCD_PARAMS_SVH
`define RCD_PARAMS_SVH

// Register byte offsets
`define RCD_ADR_W         8
`define RCD_OFS_CTRL      8'h00
`define RCD_OFS_ROUTE     8'h04
`define RCD_OFS_SER_KHZ   8'h08
`define RCD_OFS_PAR_KHZ   8'h0c
`define RCD_OFS_IF_KHZ    8'h10

// Control register field positions
`define RCD_CTRL_RUN      0
`define RCD_CTRL_BOND     1
`define RCD_BOND_W        2
`define RCD_CTRL_RM       3
`define RCD_CTRL_DSK      4
`define RCD_CTRL_BD       5
`define RCD_CTRL_HIP      6
`define RCD_CTRL_PROTO    8
`define RCD_PROTO_W       4
`define RCD_CTRL_BAD      16

// Line rates, and the hardened-core fabric clock, in kHz
`define RCD_KHZ_1G25      24'h1312d0
`define RCD_KHZ_2G5       24'h2625a0
`define RCD_KHZ_3G125     24'h2faf08
`define RCD_KHZ_OC12      24'h097db0
`define RCD_KHZ_OC48      24'h25f6c0
`define RCD_KHZ_HDSDI     24'h16a8c8
`define RCD_KHZ_HDSDI_M   24'h16a2ec
`define RCD_KHZ_SDI3G     24'h2d5190
`define RCD_KHZ_SDI3G_M   24'h2d45d8
`define RCD_KHZ_5G        24'h4c4b40
`define RCD_KHZ_BASIC     24'h2625a0
`define RCD_KHZ_HIP_IF    24'h03d090

// Deserializer width ratios and the zero rate
`define RCD_DIV_10B       24'h00000a
`define RCD_SHIFT_8B      3
`define RCD_KHZ_ZERO      24'h000000

`endif

// File: pkg/rcd_pkg.sv
// Purpose: Types for the receive clock distribution block.
// Assumes: Enumerations are numbered in declaration order from zero.
// Notes:   The route record is what the datapath clock muxes consume.
package rcd_pkg;

	typedef enum logic [3:0] {
		RCD_P_SRIO_1G25, RCD_P_SRIO_2G5, RCD_P_SRIO_3G125, RCD_P_OC12,
		RCD_P_OC48, RCD_P_HDSDI, RCD_P_HDSDI_M, RCD_P_SDI3G,
		RCD_P_SDI3G_M, RCD_P_PCIE_G1, RCD_P_PCIE_G2, RCD_P_GBE,
		RCD_P_XAUI, RCD_P_BASIC
	} rcd_proto_t;

	typedef enum logic [1:0] {RCD_B_NONE, RCD_B_X4, RCD_B_X8} rcd_bond_t;

	typedef enum logic [2:0] {
		RCD_S_NONE, RCD_S_OWN_REC, RCD_S_CH0_REC, RCD_S_TX_LOCAL,
		RCD_S_TX_PCS, RCD_S_SHARED
	} rcd_src_t;

	typedef enum logic [1:0] {
		RCD_O_NONE, RCD_O_RX_CLKOUT, RCD_O_TX_CLKOUT, RCD_O_CORE_CLKOUT
	} rcd_port_t;

	typedef struct packed {
		logic      shared_ptr;
		logic      halve;
		rcd_port_t fabric_port;
		rcd_src_t  pcf_wr;
		rcd_src_t  bd_rd;
		rcd_src_t  bd_wr;
		rcd_src_t  decoder;
		rcd_src_t  rm_rd;
		rcd_src_t  rm_wr;
		rcd_src_t  deskew;
		rcd_src_t  aligner;
	} rcd_route_t;

	typedef struct packed {
		logic       run;
		rcd_bond_t  bond;
		logic       rm_en;
		logic       dsk_en;
		logic       bd_en;
		logic       hip_en;
		rcd_proto_t proto;
	} rcd_cfg_t;

	typedef struct packed {
		rcd_cfg_t    cfg;
		rcd_route_t  route;
		logic        bad;
		logic [23:0] ser_khz;
		logic [23:0] par_khz;
		logic [23:0] if_khz;
		logic        ack;
		logic [31:0] rdata;
	} rcd_state_t;

endpackage : rcd_pkg

// File: src/rcd_clock_dist.sv
// Purpose: Receive-side clock routing and rate bookkeeping for one
//          transceiver channel group, programmed over classic Wishbone.
// Assumes: Configuration is written while the datapath is held in reset.
// Notes:   Outputs are select codes for the clock muxes, not clocks.
//
// Behaviour
// R01 - Serial recovered clock runs at half the line rate.
// R02 - Deserializer uses serial clock; divided copy forms parallel recovered clock.
// R03 - Unbonded with rate matcher: aligner and FIFO write use own recovered clock.
// R04 - Unbonded with rate matcher: FIFO read, decoder, byte write use local clock.
// R05 - Unbonded with rate matcher: phase FIFO and transmit port use PCS clock.
// R06 - Fabric captures unbonded rate-matched data on the transmit parallel port.
// R07 - Unmatched unbonded rates: SRIO 312.5, HD-SDI 148.5, OC-12 77.75 MHz.
// R08 - Rate-matched rates: GbE 125 MHz, second-generation PCIe 500 MHz.
// R09 - First-generation PCIe with hardened core gives 250 MHz fabric clock.
// R10 - Four-lane bonding in a block; eight-lane bonding only for PCIe.
// R11 - Rate matcher used unbonded for PCIe, GbE, SRIO and generic matched.
// R12 - Deskew FIFO only for four-lane XAUI; four-lane PCIe has none.
// R13 - Deskew bonding: own clock to aligner, lane zero clock to deskew, FIFO.
// R14 - Deskew bonding: shared divider clocks FIFO read, decoder, byte write.
// R15 - Bonded: phase FIFOs on shared clock, halved with byte deserializer.
// R16 - Bonded phase FIFOs share pointers from the shared management unit.
// R17 - Bonding without deskew: own clock to aligner and rate FIFO write.
// R18 - Bonded XAUI at 3.125 Gbps: 1.5625 GHz serial, 312.5 MHz parallel.
// R19 - Four-lane PCIe with byte deserializer: 125 or 250 MHz fabric clock.
// R20 - Fabric captures bonded lanes on the shared core clock output.
// R21 - Unmatched with byte deserializer: halved recovered clock on read side.
// R22 - Mode selections are static, frozen while the datapath runs.
// R23 - Only rate match and phase FIFOs cross between clock domains.
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_params.svh"

module rcd_clock_dist
	import rcd_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [`RCD_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Clock routing to the datapath
	output rcd_route_t                 route,
	output logic                       dp_run,
	output logic                       cfg_bad
);

	rcd_state_t st_r;
	rcd_state_t st_nxt;

	// Line rate in kHz for each protocol setting
	function automatic logic [23:0] rcd_rate(input rcd_proto_t p);
		logic [23:0] r;
		r = `RCD_KHZ_BASIC;
		case (p)
			RCD_P_SRIO_1G25:  r = `RCD_KHZ_1G25;
			RCD_P_SRIO_2G5:   r = `RCD_KHZ_2G5;
			RCD_P_SRIO_3G125: r = `RCD_KHZ_3G125;
			RCD_P_OC12:       r = `RCD_KHZ_OC12;
			RCD_P_OC48:       r = `RCD_KHZ_OC48;
			RCD_P_HDSDI:      r = `RCD_KHZ_HDSDI;
			RCD_P_HDSDI_M:    r = `RCD_KHZ_HDSDI_M;
			RCD_P_SDI3G:      r = `RCD_KHZ_SDI3G;
			RCD_P_SDI3G_M:    r = `RCD_KHZ_SDI3G_M;
			RCD_P_PCIE_G1:    r = `RCD_KHZ_2G5;
			RCD_P_PCIE_G2:    r = `RCD_KHZ_5G;
			RCD_P_GBE:        r = `RCD_KHZ_1G25;
			RCD_P_XAUI:       r = `RCD_KHZ_3G125;
			default:          r = `RCD_KHZ_BASIC;
		endcase
		return r;
	endfunction : rcd_rate

	// Legal mode combinations; anything else parks every clock
	function automatic logic rcd_legal(input rcd_cfg_t c);
		logic ok;
		logic is_pcie;
		logic is_srio;
		logic no_rm;
		ok      = 1'b0;
		is_pcie = (c.proto == RCD_P_PCIE_G1) || (c.proto == RCD_P_PCIE_G2);
		is_srio = (c.proto == RCD_P_SRIO_1G25) || (c.proto == RCD_P_SRIO_2G5) ||
			(c.proto == RCD_P_SRIO_3G125);
		no_rm   = is_srio || (c.proto == RCD_P_BASIC) || (c.proto == RCD_P_OC12) ||
			(c.proto == RCD_P_OC48) || (c.proto == RCD_P_HDSDI) ||
			(c.proto == RCD_P_HDSDI_M) || (c.proto == RCD_P_SDI3G) ||
			(c.proto == RCD_P_SDI3G_M);
		case (c.bond)
			RCD_B_NONE: begin
				// Matched set versus unmatched set  [R11]
				if (c.rm_en) begin
					ok = !c.dsk_en && (is_pcie || is_srio || (c.proto == RCD_P_GBE) ||
						(c.proto == RCD_P_BASIC)); // [R11]
				end else begin
					ok = !c.dsk_en && no_rm;
				end
			end
			RCD_B_X4: begin
				// Deskew belongs to XAUI alone  [R10] [R12]
				if (c.proto == RCD_P_XAUI) begin
					ok = c.dsk_en; // [R12]
				end else begin
					ok = !c.dsk_en && (is_pcie || (c.proto == RCD_P_BASIC)); // [R12]
				end
			end
			RCD_B_X8: begin
				ok = !c.dsk_en && is_pcie; // [R10]
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction : rcd_legal

	// Select codes for every clock consumer in the receive path
	function automatic rcd_route_t rcd_map(input rcd_cfg_t c);
		rcd_route_t r;
		r = '0;
		r.aligner = RCD_S_OWN_REC; // [R03] [R13] [R17]
		r.halve   = c.bd_en;
		if (c.bond == RCD_B_NONE && !c.rm_en) begin
			// Recovered clock runs the whole channel; no FIFO but the phase one
			r.decoder     = RCD_S_OWN_REC;
			r.bd_wr       = RCD_S_OWN_REC;
			r.bd_rd       = RCD_S_OWN_REC; // [R21]
			r.pcf_wr      = RCD_S_OWN_REC; // [R21]
			r.fabric_port = RCD_O_RX_CLKOUT;
		end else if (c.bond == RCD_B_NONE) begin
			// Rate FIFO moves data onto the local transmit clock  [R23]
			r.rm_wr       = RCD_S_OWN_REC;   // [R03]
			r.rm_rd       = RCD_S_TX_LOCAL;  // [R04]
			r.decoder     = RCD_S_TX_LOCAL;  // [R04]
			r.bd_wr       = RCD_S_TX_LOCAL;  // [R04]
			r.bd_rd       = RCD_S_TX_PCS;    // [R05]
			r.pcf_wr      = RCD_S_TX_PCS;    // [R05]
			r.fabric_port = RCD_O_TX_CLKOUT; // [R05] [R06]
		end else begin
			// Bonded lanes: shared divider clock from the rate FIFO onward
			r.deskew      = c.dsk_en ? RCD_S_CH0_REC : RCD_S_NONE; // [R13]
			r.rm_wr       = c.dsk_en ? RCD_S_CH0_REC : RCD_S_OWN_REC; // [R13] [R17]
			r.rm_rd       = RCD_S_SHARED; // [R14]
			r.decoder     = RCD_S_SHARED; // [R14]
			r.bd_wr       = RCD_S_SHARED; // [R14]
			r.bd_rd       = RCD_S_SHARED; // [R15]
			r.pcf_wr      = RCD_S_SHARED; // [R15]
			r.fabric_port = RCD_O_CORE_CLKOUT; // [R15] [R20]
			r.shared_ptr  = 1'b1; // [R16]
		end
		if (!c.bd_en) begin
			// Byte deserializer bypassed, so it gets no clock at all
			r.bd_wr = RCD_S_NONE;
			r.bd_rd = RCD_S_NONE;
		end
		return r;
	endfunction : rcd_map

	// Pack the control word for readback
	function automatic logic [31:0] rcd_ctrl_word(input rcd_cfg_t c, input logic bad);
		logic [31:0] w;
		w = '0;
		w[`RCD_CTRL_RUN]                  = c.run;
		w[`RCD_CTRL_BOND +: `RCD_BOND_W]  = c.bond;
		w[`RCD_CTRL_RM]                   = c.rm_en;
		w[`RCD_CTRL_DSK]                  = c.dsk_en;
		w[`RCD_CTRL_BD]                   = c.bd_en;
		w[`RCD_CTRL_HIP]                  = c.hip_en;
		w[`RCD_CTRL_PROTO +: `RCD_PROTO_W] = c.proto;
		w[`RCD_CTRL_BAD]                  = bad;
		return w;
	endfunction : rcd_ctrl_word

	// Next state: bus slave, frozen configuration, routing and rates
	always_comb begin
		logic        req;
		logic [31:0] mask;
		logic [31:0] wcur;
		logic [31:0] wnew;
		rcd_cfg_t    cfg_n;
		logic [23:0] rate;
		logic [23:0] par;
		logic        legal;
		req    = 1'b0;
		mask   = '0;
		wcur   = '0;
		wnew   = '0;
		cfg_n  = st_r.cfg;
		rate   = '0;
		par    = '0;
		legal  = 1'b0;
		st_nxt = st_r;

		// Classic single cycle: take the request, ack one cycle later
		req         = wb_cyc_i && wb_stb_i && !st_r.ack;
		st_nxt.ack  = req;
		for (int b = 0; b < 4; b++) begin
			mask[b*8 +: 8] = {8{wb_sel_i[b]}};
		end

		// Control register write with byte lanes
		if (req && wb_we_i && wb_adr_i == `RCD_OFS_CTRL) begin
			wcur = rcd_ctrl_word(st_r.cfg, st_r.bad);
			wnew = (wcur & ~mask) | (wb_dat_i & mask);
			cfg_n.run = wnew[`RCD_CTRL_RUN];
			// Mode bits only move while the datapath is held in reset
			if (!st_r.cfg.run) begin
				cfg_n.bond   = rcd_bond_t'(wnew[`RCD_CTRL_BOND +: `RCD_BOND_W]); // [R22]
				cfg_n.rm_en  = wnew[`RCD_CTRL_RM];     // [R22]
				cfg_n.dsk_en = wnew[`RCD_CTRL_DSK];    // [R22]
				cfg_n.bd_en  = wnew[`RCD_CTRL_BD];     // [R22]
				cfg_n.hip_en = wnew[`RCD_CTRL_HIP];    // [R22]
				cfg_n.proto  = rcd_proto_t'(wnew[`RCD_CTRL_PROTO +: `RCD_PROTO_W]);
			end
		end
		st_nxt.cfg = cfg_n;

		// Routing and rates follow the stored configuration one cycle later
		legal        = rcd_legal(st_r.cfg);
		st_nxt.bad   = !legal;
		st_nxt.route = legal ? rcd_map(st_r.cfg) : '0;
		rate         = rcd_rate(st_r.cfg.proto);
		// Half-rate recovery samples on both edges  [R01]
		st_nxt.ser_khz = legal ? (rate >> 1) : `RCD_KHZ_ZERO; // [R01] [R18]
		// SONET paths deserialize 8 bits per word, all others 10  [R02]
		if (st_r.cfg.proto == RCD_P_OC12 || st_r.cfg.proto == RCD_P_OC48) begin
			par = rate >> `RCD_SHIFT_8B; // [R02] [R07]
		end else begin
			par = rate / `RCD_DIV_10B;   // [R02] [R07] [R08] [R18]
		end
		st_nxt.par_khz = legal ? par : `RCD_KHZ_ZERO;
		// Fabric clock is the parallel clock, halved behind the byte stage
		if (!legal) begin
			st_nxt.if_khz = `RCD_KHZ_ZERO;
		end else if (st_r.cfg.bd_en) begin
			st_nxt.if_khz = par >> 1; // [R15] [R19] [R21]
		end else if (st_r.cfg.proto == RCD_P_PCIE_G1 && st_r.cfg.hip_en) begin
			st_nxt.if_khz = `RCD_KHZ_HIP_IF; // [R09]
		end else begin
			st_nxt.if_khz = par; // [R07] [R08]
		end

		// Read mux; unmapped offsets read zero and still ack
		st_nxt.rdata = '0;
		if (req && !wb_we_i) begin
			if (wb_adr_i == `RCD_OFS_CTRL) begin
				st_nxt.rdata = rcd_ctrl_word(st_r.cfg, st_r.bad);
			end else if (wb_adr_i == `RCD_OFS_ROUTE) begin
				st_nxt.rdata = {4'h0, st_r.route};
			end else if (wb_adr_i == `RCD_OFS_SER_KHZ) begin
				st_nxt.rdata = {8'h00, st_r.ser_khz};
			end else if (wb_adr_i == `RCD_OFS_PAR_KHZ) begin
				st_nxt.rdata = {8'h00, st_r.par_khz};
			end else if (wb_adr_i == `RCD_OFS_IF_KHZ) begin
				st_nxt.rdata = {8'h00, st_r.if_khz};
			end else begin
				st_nxt.rdata = '0;
			end
		end
	end

	// Single state register; reset parks all clocks and holds the datapath
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign wb_dat_o = st_r.rdata;
	assign wb_ack_o = st_r.ack;
	assign route    = st_r.route;
	assign dp_run   = st_r.cfg.run;
	assign cfg_bad  = st_r.bad;

endmodule : rcd_clock_dist

`default_nettype wire

// File: testbench/rcd_fabric_model.sv
// Purpose: Fabric capture logic that follows the forwarded clock.
// Assumes: Capture starts only once the datapath runs.
// Notes:   Reports which forwarded clock it latches receive data on.
`timescale 1ns/1ps
`default_nettype none
module rcd_fabric_model
	import rcd_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Forwarded clock choice
	input  wire rcd_route_t route,
	input  wire logic       dp_run,
	// Capture clock in use
	output var rcd_port_t   cap_port
);
	// Latch only on the forwarded clock; idle fabric latches nothing
	always_ff @(posedge sys_clk) begin
		if (reset || !dp_run)
			cap_port <= RCD_O_NONE;
		else
			cap_port <= route.fabric_port;
	end
endmodule : rcd_fabric_model
`default_nettype wire

// File: testbench/rcd_clock_dist_asserts.sv
// Purpose: Port-level checks of the receive clock router.
// Assumes: One clock domain, synchronous reset.
// Notes:   Route fields are checked as relations, not as a copy.
`timescale 1ns/1ps
`default_nettype none
module rcd_clock_dist_asserts
	import rcd_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Wishbone
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	// Routing
	input  wire rcd_route_t  route,
	input  wire logic        dp_run,
	input  wire logic        cfg_bad
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Unanswered request, then a single ack pulse
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_next: assert property (s_req |=> s_ans)
		else $error("ack late or too long");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_bad_dark: assert property (cfg_bad |-> route == '0)
		else $error("illegal mode still routed");
	a_rm_local: assert property (route.fabric_port == RCD_O_TX_CLKOUT |->
		route.rm_rd == RCD_S_TX_LOCAL && route.decoder == RCD_S_TX_LOCAL
		&& route.aligner == RCD_S_OWN_REC && route.rm_wr == RCD_S_OWN_REC)
		else $error("rate matched clocks wrong");
	a_pcs_fwd: assert property (route.fabric_port == RCD_O_TX_CLKOUT |->
		route.pcf_wr == RCD_S_TX_PCS) else $error("phase fifo not on pcs clock");
	a_core_shared: assert property (route.fabric_port == RCD_O_CORE_CLKOUT |->
		route.pcf_wr == RCD_S_SHARED && route.shared_ptr)
		else $error("bonded phase fifo not shared");
	a_lane0_deskew: assert property (route.deskew == RCD_S_CH0_REC |->
		route.rm_wr == RCD_S_CH0_REC && route.rm_rd == RCD_S_SHARED
		&& route.aligner == RCD_S_OWN_REC) else $error("deskew clocks wrong");
	a_own_fifo_wr: assert property (route.fabric_port == RCD_O_CORE_CLKOUT
		&& route.deskew == RCD_S_NONE |-> route.rm_wr == RCD_S_OWN_REC)
		else $error("bonded fifo write not own clock");
	a_mode_frozen: assert property (dp_run && $past(dp_run, 3) |-> $stable(route))
		else $error("route moved while running");
endmodule : rcd_clock_dist_asserts
bind rcd_clock_dist rcd_clock_dist_asserts rcd_clock_dist_asserts_inst (.sys_clk,
	.reset, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .route, .dp_run, .cfg_bad);
`default_nettype wire

// File: testbench/rcd_clock_dist_tb.sv
// Purpose: Self-checking bench for the receive clock router.
// Assumes: The slave answers in its own time; every wait is bounded.
// Notes:   Expected rates are worked out by hand in kHz.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_params.svh"
module rcd_clock_dist_tb
	import rcd_pkg::*;
;
	logic        sys_clk, reset, cyc, stb, we, wb_ack_o, dp_run, cfg_bad;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rd, wb_dat_o;
	rcd_route_t  route;
	rcd_port_t   cap_port;
	int          failures, comparisons;

	rcd_clock_dist rcd_clock_dist_inst (.sys_clk, .reset, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .route, .dp_run, .cfg_bad);
	rcd_fabric_model rcd_fabric_model_inst (.sys_clk, .reset, .route, .dp_run,
		.cap_port);

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish;
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; held until ack is sampled, only the watchdog ends a wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// Program a mode with run low, then read back rates and the fault flag
	task automatic cfg(input logic [15:0] c, input logic [23:0] par, ifk,
		input logic bad);
		wb(1'b1, `RCD_OFS_CTRL, {16'h0000, c});
		wb(1'b0, `RCD_OFS_PAR_KHZ, 32'h0);
		chk(rd, {8'h00, par});
		wb(1'b0, `RCD_OFS_IF_KHZ, 32'h0);
		chk(rd, {8'h00, ifk});
		chk({31'h0, cfg_bad}, {31'h0, bad});
	endtask : cfg

	// Watchdog well beyond the expected run
	initial begin
		#40000;
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		reset = 1'b1;
		failures = 0;
		comparisons = 0;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		wb(1'b0, `RCD_OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		cfg(16'h0b08, 24'h01e848, 24'h01e848, 1'b0);
		wb(1'b0, `RCD_OFS_SER_KHZ, 32'h0);
		chk(rd, 32'h00098968);
		chk(32'({route.aligner, route.rm_wr, route.rm_rd, route.decoder, route.pcf_wr,
			route.fabric_port}), 32'({RCD_S_OWN_REC, RCD_S_OWN_REC, RCD_S_TX_LOCAL,
			RCD_S_TX_LOCAL, RCD_S_TX_PCS, RCD_O_TX_CLKOUT}));
		wb(1'b1, `RCD_OFS_CTRL, 32'h00000b09);
		wb(1'b1, `RCD_OFS_CTRL, 32'h00000c13);
		wb(1'b0, `RCD_OFS_CTRL, 32'h0);
		chk(rd, 32'h00000b09);
		chk(32'({dp_run, cap_port}), 32'({1'b1, RCD_O_TX_CLKOUT}));
		wb(1'b1, `RCD_OFS_CTRL, 32'h00000b08);
		cfg(16'h0b28, 24'h01e848, 24'h00f424, 1'b0);
		chk({31'h0, route.halve}, 32'h1);
		cfg(16'h0a08, 24'h07a120, 24'h07a120, 1'b0);
		cfg(16'h0948, 24'h03d090, 24'h03d090, 1'b0);
		cfg(16'h0200, 24'h04c4b4, 24'h04c4b4, 1'b0);
		cfg(16'h0300, 24'h012fb6, 24'h012fb6, 1'b0);
		cfg(16'h0500, 24'h024414, 24'h024414, 1'b0);
		cfg(16'h0520, 24'h024414, 24'h01220a, 1'b0);
		cfg(16'h0308, 24'h000000, 24'h000000, 1'b1);
		cfg(16'h0c02, 24'h000000, 24'h000000, 1'b1);
		cfg(16'h0912, 24'h000000, 24'h000000, 1'b1);
		cfg(16'h0c04, 24'h000000, 24'h000000, 1'b1);
		cfg(16'h0006, 24'h000000, 24'h000000, 1'b1);
		cfg(16'h0904, 24'h03d090, 24'h03d090, 1'b0);
		cfg(16'h0922, 24'h03d090, 24'h01e848, 1'b0);
		chk(32'({route.aligner, route.rm_wr, route.fabric_port, route.halve}),
			32'({RCD_S_OWN_REC, RCD_S_OWN_REC, RCD_O_CORE_CLKOUT, 1'b1}));
		cfg(16'h0a22, 24'h07a120, 24'h03d090, 1'b0);
		cfg(16'h0c12, 24'h04c4b4, 24'h04c4b4, 1'b0);
		wb(1'b0, `RCD_OFS_SER_KHZ, 32'h0);
		chk(rd, 32'h0017d784);
		chk(32'({route.deskew, route.rm_wr, route.rm_rd, route.decoder, route.pcf_wr,
			route.shared_ptr}), 32'({RCD_S_CH0_REC, RCD_S_CH0_REC, RCD_S_SHARED,
			RCD_S_SHARED, RCD_S_SHARED, 1'b1}));
		wb(1'b1, `RCD_OFS_CTRL, 32'h00000c13);
		wb(1'b0, `RCD_OFS_ROUTE, 32'h0);
		chk(rd, 32'({4'h0, 1'b1, 1'b0, RCD_O_CORE_CLKOUT, RCD_S_SHARED, RCD_S_NONE,
			RCD_S_NONE, RCD_S_SHARED, RCD_S_SHARED, RCD_S_CH0_REC, RCD_S_CH0_REC,
			RCD_S_OWN_REC}));
		chk(32'(cap_port), 32'(RCD_O_CORE_CLKOUT));
		tally_and_finish();
	end
endmodule : rcd_clock_dist_tb
`default_nettype wire
